// ### design/liquid_dispenser_control.sv
// sequencer for the hands-free dispenser: sleep, periodic beam check, dispense, alarm
module liquid_dispenser_control #(
  parameter int unsigned WAKE_CYCLES     = dispenser_pkg::WAKE_CYCLES_DEF,
  parameter int unsigned DISPENSE_CYCLES = dispenser_pkg::DISPENSE_CYCLES_DEF,
  parameter int unsigned TONE_CYCLES     = dispenser_pkg::TONE_CYCLES_DEF,
  parameter int unsigned PWM_PERIOD      = dispenser_pkg::PWM_PERIOD_DEF
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  // asynchronous pins
  input  wire dispenser_pkg::sense_t        sensePins,
  // drives
  output dispenser_pkg::drive_t             drive,
  // status and power-on configuration
  output logic                              sleeping,
  output dispenser_pkg::option_bytes_t      optionBytes
);
  import dispenser_pkg::*;

  typedef struct packed {
    ctrl_state_t   state;
    sense_t        syncA;
    sense_t        syncB;
    logic [31:0]   wakeCnt;
    logic [31:0]   dispCnt;
    logic [3:0]    stepCnt;
    logic          active;
    logic          lockout;
    logic          lightMode;
    logic          lowBat;
    logic          alarmGate;
    logic          motorOn;
    logic          ledOn;
    logic          buzzOn;
    logic          emitterOn;
    option_bytes_t opt;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{state: ST_INIT, opt: OPTION_BYTES, default: '0};

  // refuse timings the counters cannot serve
  if (WAKE_CYCLES < 16 || DISPENSE_CYCLES < 2 ||
      TONE_CYCLES < 2 || PWM_PERIOD < 4) begin : g_badParams
    $error("liquid_dispenser_control: timing parameter too small");
  end

  function automatic logic [31:0] dutyCount(input int unsigned pct);
    dutyCount = 32'(PWM_PERIOD * pct / PCT_FULL);
  endfunction : dutyCount

  ctrl_t st_reg;
  ctrl_t st_next;
  logic  wakeTick;
  logic  dispExpire;
  logic  motorWave;
  logic  toneWave;

  assign wakeTick   = (st_reg.wakeCnt == WAKE_CYCLES - 1);
  assign dispExpire = st_reg.active && (st_reg.dispCnt == DISPENSE_CYCLES - 1);

  // next-state logic for the whole controller
  always_comb begin
    st_next       = st_reg;
    // pins pass two flops before any decision looks at them
    st_next.syncA = sensePins;
    st_next.syncB = st_reg.syncA;
    // interval timer, free running once init is done
    if (st_reg.state == ST_INIT || wakeTick) begin
      st_next.wakeCnt = 32'h0;
    end else begin
      st_next.wakeCnt = st_reg.wakeCnt + 32'h1;
    end
    // dispense time limit, lockout until the hand is withdrawn
    if (dispExpire) begin
      st_next.active  = 1'b0;
      st_next.lockout = 1'b1;
    end else if (st_reg.active) begin
      st_next.dispCnt = st_reg.dispCnt + 32'h1;
    end
    // alarm gate flips on every wake tick while the alarm sounds
    if (wakeTick && st_reg.active && st_reg.lowBat) begin
      st_next.alarmGate = !st_reg.alarmGate;
    end
    case (st_reg.state)
      ST_INIT: begin
        st_next.opt     = OPTION_BYTES;
        st_next.stepCnt = st_reg.stepCnt + 4'h1;
        if (st_reg.stepCnt == INIT_LAST) begin
          st_next.state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (wakeTick) begin
          st_next.state   = ST_CHECK;
          st_next.stepCnt = 4'h0;
        end
      end
      ST_ACTIVE: begin
        if (dispExpire) begin
          st_next.state = ST_STOP;
        end else if (wakeTick) begin
          st_next.state   = ST_CHECK;
          st_next.stepCnt = 4'h0;
        end
      end
      ST_CHECK: begin
        st_next.stepCnt = st_reg.stepCnt + 4'h1;
        if (st_reg.stepCnt == SENSE_LAST) begin
          if (!st_reg.syncB.beamBlocked) begin
            st_next.active  = 1'b0;
            st_next.lockout = 1'b0;
            st_next.state   = ST_STOP;
          end else if (st_next.active) begin
            st_next.state = ST_ACTIVE;
          end else if (st_next.lockout) begin
            st_next.state = ST_STOP;
          end else begin
            st_next.active    = 1'b1;
            st_next.dispCnt   = 32'h0;
            st_next.lightMode = st_reg.syncB.lightSel;
            st_next.lowBat    = st_reg.syncB.batteryLow;
            st_next.alarmGate = 1'b1;
            st_next.state     = ST_ACTIVE;
          end
        end
      end
      default: begin
        st_next.state = ST_INIT;
      end
    endcase
    // output enables held in flops so pins never glitch
    st_next.motorOn   = st_next.active && !st_next.lowBat;
    st_next.ledOn     = st_next.active && !st_next.lowBat;
    st_next.buzzOn    = st_next.active && (!st_next.lowBat || st_next.alarmGate);
    st_next.emitterOn = (st_next.state == ST_CHECK);
  end

  // reset is trusted to be released only once the clock is stable
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg <= CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // motor PWM, duty picked by the mode latched at detection
  square_gen u_motorPwm (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .en      (st_reg.motorOn),
    .period  (32'(PWM_PERIOD)),
    .onCount (st_reg.lightMode ? dutyCount(LIGHT_DUTY_PCT) : dutyCount(NORMAL_DUTY_PCT)),
    .wave    (motorWave)
  );

  // buzzer tone; half of the period high
  square_gen u_tone (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .en      (st_reg.buzzOn),
    .period  (32'(TONE_CYCLES)),
    .onCount (32'(TONE_CYCLES / 2)),
    .wave    (toneWave)
  );

  assign drive.motor   = motorWave;
  assign drive.led     = st_reg.ledOn;
  assign drive.buzzer  = toneWave;
  assign drive.emitter = st_reg.emitterOn;
  assign sleeping      = (st_reg.state == ST_STOP);
  assign optionBytes   = st_reg.opt;

  // checks on the controller's own registers and outputs
  a_init_to_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg.state == ST_INIT && st_reg.stepCnt == INIT_LAST |=> st_reg.state == ST_STOP)
    else $error("init did not end in stop state");

  a_wake_period: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wakeTick |-> $past(st_reg.wakeCnt) == WAKE_CYCLES - 2)
    else $error("wake tick at wrong count");

  a_normal_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg.active && !st_reg.lowBat && !st_reg.lightMode ##1 st_reg.motorOn[*2]
    |-> drive.motor && drive.led)
    else $error("normal mode motor not full on");

  a_light_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg.active && !st_reg.lowBat |-> st_reg.ledOn && st_reg.buzzOn && st_reg.motorOn)
    else $error("dispense indication missing");

  a_lowbat_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg.lowBat |-> !drive.led && !st_reg.motorOn && !drive.motor)
    else $error("motor or led on in low battery");

  a_config_bytes: assert property (@(posedge sys_clk) disable iff (!rst_b)
    optionBytes.watchdog == 8'hef && optionBytes.lowVoltageDetector == 8'h7f)
    else $error("watchdog or detector setting wrong");

  a_config_clock: assert property (@(posedge sys_clk) disable iff (!rst_b)
    optionBytes.clock == 8'had)
    else $error("clock setting wrong");

  a_config_debug: assert property (@(posedge sys_clk) disable iff (!rst_b)
    optionBytes.debug == 8'h04)
    else $error("debug setting wrong");

  a_dispense_limit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg.active |-> st_reg.dispCnt < DISPENSE_CYCLES)
    else $error("dispense ran past its limit");

  a_alarm_toggle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wakeTick && st_reg.active && st_reg.lowBat && !dispExpire
    |=> st_reg.alarmGate != $past(st_reg.alarmGate))
    else $error("alarm gate did not toggle");

  a_no_hand_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg.state == ST_CHECK && st_reg.stepCnt == SENSE_LAST && !st_reg.syncB.beamBlocked
    |=> sleeping && !st_reg.active ##1 !drive.led && !st_reg.buzzOn)
    else $error("outputs not off after empty check");

  a_mode_sample: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg.state == ST_CHECK && st_reg.stepCnt == SENSE_LAST && st_reg.syncB.beamBlocked
    && !st_reg.active && !st_reg.lockout
    |=> st_reg.active && st_reg.lightMode == $past(st_reg.syncB.lightSel))
    else $error("mode not sampled at detection");
endmodule : liquid_dispenser_control

// ### design/dispenser_defs.sv
// constants, carrier types and square-wave generator for the liquid dispenser control
// Behaviour
// - initialise everything, then enter stop state
// - interval timer wakes controller every 50 ms
// - light mode hand: motor, LED, buzzer on
// - normal mode hand: motor, LED, buzzer on
// - low battery: buzzer alarm only, no motor/LED
// - watchdog stopped, voltage detector off settings
// - operating clock setting selects 1 MHz
// - on-chip debug disabled setting
// - dispensing stops after at most 2 s
// - motor PWM 100% normal, 75% light
// - buzzer carries 1.8 kHz square wave
// - low battery buzzer gated every 50 ms
package dispenser_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned WAKE_PERIOD_MS  = 50;
  localparam int unsigned WAKE_CYCLES_DEF = CLK_HZ / 1000 * WAKE_PERIOD_MS;
  localparam int unsigned DISPENSE_MAX_MS = 2000;
  localparam int unsigned DISPENSE_CYCLES_DEF = CLK_HZ / 1000 * DISPENSE_MAX_MS;
  localparam int unsigned TONE_HZ         = 1800;
  localparam int unsigned TONE_CYCLES_DEF = CLK_HZ / TONE_HZ;
  localparam int unsigned PWM_PERIOD_DEF  = 1000;
  localparam int unsigned NORMAL_DUTY_PCT = 100;
  localparam int unsigned LIGHT_DUTY_PCT  = 75;
  localparam int unsigned PCT_FULL        = 100;
  // short waits in cycles: init sequence and emitter settle before sampling
  localparam logic [3:0]  INIT_LAST       = 4'h7;
  localparam logic [3:0]  SENSE_LAST      = 4'h3;
  // power-on configuration bytes
  localparam logic [7:0]  WDT_OPTION      = 8'hef;
  localparam logic [7:0]  LVD_OPTION      = 8'h7f;
  localparam logic [7:0]  CLK_OPTION      = 8'had;
  localparam logic [7:0]  DEBUG_OPTION    = 8'h04;

  typedef struct packed {
    logic [7:0] watchdog;
    logic [7:0] lowVoltageDetector;
    logic [7:0] clock;
    logic [7:0] debug;
  } option_bytes_t;

  localparam option_bytes_t OPTION_BYTES = '{WDT_OPTION, LVD_OPTION, CLK_OPTION, DEBUG_OPTION};

  typedef enum logic [1:0] {ST_INIT, ST_STOP, ST_CHECK, ST_ACTIVE} ctrl_state_t;

  // pins from the sensor, selector switch and battery comparator
  typedef struct packed {
    logic beamBlocked;
    logic lightSel;
    logic batteryLow;
  } sense_t;

  // drives toward motor, LED, buzzer and infrared emitter
  typedef struct packed {
    logic motor;
    logic led;
    logic buzzer;
    logic emitter;
  } drive_t;
endpackage : dispenser_pkg

// free-running square or PWM wave, forced low and restarted while disabled
module square_gen (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // control
  input  wire logic        en,
  input  wire logic [31:0] period,
  input  wire logic [31:0] onCount,
  // wave
  output logic             wave
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        wave;
  } gen_t;

  gen_t st_reg;
  gen_t st_next;

  // wave is high for the first onCount cycles of each period
  always_comb begin
    st_next = st_reg;
    if (!en) begin
      st_next = '0;
    end else begin
      st_next.wave = (st_reg.cnt < onCount);
      st_next.cnt  = (st_reg.cnt >= period - 32'h1) ? 32'h0 : st_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wave = st_reg.wave;
endmodule : square_gen

// ### sim/dispenser_far_side.sv
// far-side model: infrared beam, phototransistor, selector switch, battery comparator
module dispenser_far_side
  import dispenser_pkg::*;
(
  // scene chosen by the bench
  input  wire logic   handPresent,
  input  wire logic   lightSw,
  input  wire logic   batLow,
  // device side
  input  wire drive_t drive,
  output sense_t      sensePins
);
  timeunit 1ns;
  timeprecision 1ps;
  // emitter dark leaves the collector high, which looks like a cut beam
  assign sensePins = '{beamBlocked: handPresent | ~drive.emitter,
                       lightSel:    lightSw,
                       batteryLow:  batLow};
endmodule : dispenser_far_side

// ### sim/liquid_dispenser_control_tb_top.sv
// self-checking bench for the dispenser sequencer
module liquid_dispenser_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dispenser_pkg::*;
  localparam int unsigned WAKE  = 64;
  localparam int unsigned LIMIT = 400;
  logic          sys_clk     = 1'b0;
  logic          rst_b       = 1'b0;
  logic          handPresent = 1'b0;
  logic          lightSw     = 1'b0;
  logic          batLow      = 1'b0;
  sense_t        sensePins;
  drive_t        drive;
  logic          sleeping;
  option_bytes_t optionBytes;
  int            fails           = 0;
  int            samples_checked = 0;
  logic [31:0]   hiCnt, ledCnt, edgeCnt;

  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  liquid_dispenser_control #(.WAKE_CYCLES(WAKE), .DISPENSE_CYCLES(LIMIT),
                             .TONE_CYCLES(8), .PWM_PERIOD(8)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .sensePins(sensePins), .drive(drive),
    .sleeping(sleeping), .optionBytes(optionBytes));

  dispenser_far_side far_u (
    .handPresent(handPresent), .lightSw(lightSw), .batLow(batLow),
    .drive(drive), .sensePins(sensePins));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check_val

  // inputs change 1 ns after the rising edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  function automatic logic pick(input int sel);
    case (sel)
      0: return drive.led;
      1: return drive.emitter;
      default: return sleeping;
    endcase
  endfunction : pick

  // bounded wait; a hang ends the run rather than stalling it
  task automatic wait_bit(input int sel, input logic lvl, input int bound, output int n);
    for (n = 0; n < bound && pick(sel) !== lvl; n++) step(1);
    if (pick(sel) !== lvl) begin
      fails++;
      $display("[ERR] wait %0d expected %0b seen timeout", sel, lvl);
      print_verdict();
    end
  endtask : wait_bit

  // motor-high and led-high cycles and buzzer edges over a window
  task automatic measure(input int n);
    logic prevBuz;
    hiCnt = 0;
    ledCnt = 0;
    edgeCnt = 0;
    prevBuz = drive.buzzer;
    repeat (n) begin
      step(1);
      hiCnt += drive.motor;
      ledCnt += drive.led;
      edgeCnt += (drive.buzzer !== prevBuz);
      prevBuz = drive.buzzer;
    end
  endtask : measure

  // hand leaves: next check must shut everything and sleep
  // waits for the emitter first, since a lockout may already sleep
  task automatic hand_off();
    int n;
    handPresent = 1'b0;
    wait_bit(1, 1'b1, WAKE + 20, n);
    wait_bit(2, 1'b1, 10, n);
    step(2);
    check_val("drives idle", 0, drive);
  endtask : hand_off

  task automatic t_reset();
    int n, k;
    step(20);
    check_val("drives in reset", 0, drive);
    check_val("option bytes", {8'hef, 8'h7f, 8'had, 8'h04}, optionBytes);
    rst_b = 1'b1;
    wait_bit(2, 1'b1, 12, n);
    wait_bit(1, 1'b1, WAKE + 20, n);
    wait_bit(1, 1'b0, 10, k);
    check_val("emitter width", 4, k);
    wait_bit(1, 1'b1, WAKE, n);
    check_val("wake period", WAKE, k + n);
    check_val("option bytes run", {8'hef, 8'h7f, 8'had, 8'h04}, optionBytes);
    $display("test reset done");
  endtask : t_reset

  // selector flipped mid-dispense must not change the running mode
  task automatic t_dispense(input logic light, input logic [31:0] expHi);
    int n;
    lightSw = light;
    handPresent = 1'b1;
    wait_bit(0, 1'b1, WAKE + 20, n);
    lightSw = ~light;
    step(2);
    measure(64);
    check_val("led on", 64, ledCnt);
    check_val("motor duty", expHi, hiCnt);
    check_val("tone edges", 1, edgeCnt >= 15 && edgeCnt <= 17);
    hand_off();
    $display("test dispense %0b done", light);
  endtask : t_dispense

  task automatic t_lowbat();
    int n;
    batLow = 1'b1;
    handPresent = 1'b1;
    wait_bit(1, 1'b1, WAKE + 20, n);
    wait_bit(1, 1'b0, 10, n);
    step(2);
    measure(128);
    check_val("alarm led", 0, ledCnt);
    check_val("alarm motor", 0, hiCnt);
    check_val("gated edges", 1, edgeCnt >= 12 && edgeCnt <= 20);
    hand_off();
    batLow = 1'b0;
    $display("test lowbat done");
  endtask : t_lowbat

  task automatic t_limit();
    int n;
    handPresent = 1'b1;
    wait_bit(0, 1'b1, WAKE + 20, n);
    step(LIMIT - 40);
    check_val("still dispensing", 1, drive.led);
    step(60);
    check_val("limit stop", 0, {drive.led, drive.motor});
    step(2 * WAKE);
    check_val("lockout", 0, {drive.led, drive.motor});
    hand_off();
    $display("test limit done");
  endtask : t_limit

  initial begin
    t_reset();
    t_dispense(1'b0, 32'd64);
    t_dispense(1'b1, 32'd48);
    t_lowbat();
    t_limit();
    print_verdict();
  end
endmodule : liquid_dispenser_control_tb_top
